// file: rtl/shc_converter.sv
// Purpose: static huffman encoder by table index and bitwise decoder by search
// Assumes: code table loaded by the system before any conversion starts
// Notes:   one bit per decode loop; invalid code flagged at the longest length
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - symbols are exactly one byte
// - encode uses symbol as table index
// - decode shifts stream one bit per step
// - search with register after every bit
// - no match below 48 bits keeps bits, shifts next
// - match outputs symbol, clears register
// - codes up to 48 bits
// - loop is shift, search, flag test
module shc_converter #(
  parameter int unsigned SYMS = 256
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  // table load port, written by the system
  input  wire logic                       tbl_we,
  input  wire logic [shc_pkg::SYM_W-1:0]  tbl_idx,
  input  wire logic [shc_pkg::CODE_W-1:0] tbl_code,
  input  wire logic [shc_pkg::LEN_W-1:0]  tbl_len,
  // encoder
  input  wire logic                       enc_valid,
  input  wire logic [shc_pkg::SYM_W-1:0]  enc_sym,
  output logic                            enc_out_valid,
  output logic [shc_pkg::CODE_W-1:0]      enc_code,
  output logic [shc_pkg::LEN_W-1:0]       enc_len,
  // decoder bit stream
  input  wire logic                       bit_valid,
  input  wire logic                       bit_in,
  output logic                            bit_ready,
  output logic                            dec_valid,
  output logic [shc_pkg::SYM_W-1:0]       dec_sym,
  output logic                            dec_err,
  // external associative memory
  output logic                            cam_req,
  output logic [shc_pkg::CODE_W-1:0]      cam_key,
  output logic [shc_pkg::LEN_W-1:0]       cam_len,
  input  wire logic                       cam_ack,
  input  wire logic                       cam_match,
  input  wire logic [shc_pkg::SYM_W-1:0]  cam_sym
);
  typedef enum logic [1:0] {SHC_IDLE, SHC_SEARCH, SHC_WAIT} shc_state_t;

  // longest code length, counter step and loop budget at their own widths
  localparam logic [shc_pkg::LEN_W-1:0] LEN_FULL = shc_pkg::LEN_W'(shc_pkg::CODE_W);
  localparam logic [shc_pkg::CNT_W-1:0] CNT_ONE  = shc_pkg::CNT_W'(1);
  localparam logic [shc_pkg::CNT_W-1:0] LOOP_MAX = shc_pkg::CNT_W'(shc_pkg::LOOP_CYC);

  // true when the input register holds a code of the longest legal length
  function automatic logic shc_is_full(input logic [shc_pkg::LEN_W-1:0] n);
    return n == LEN_FULL;
  endfunction : shc_is_full

  shc_state_t                 state_q;   // decode loop state
  logic [shc_pkg::CODE_W-1:0] shreg_q;   // input shift register
  logic [shc_pkg::LEN_W-1:0]  nbits_q;   // bits held
  logic [shc_pkg::CODE_W-1:0] code_mem [SYMS];  // code array
  logic [shc_pkg::LEN_W-1:0]  len_mem  [SYMS];  // length array
  logic [shc_pkg::CNT_W-1:0]  loop_q;    // cycles in current loop

  shc_cam_if cif ();

  // search port logic
  shc_cam_port u_port (
    .clk       (clk),
    .srst      (srst),
    .cif       (cif),
    .cam_req   (cam_req),
    .cam_key   (cam_key),
    .cam_len   (cam_len),
    .cam_ack   (cam_ack),
    .cam_match (cam_match),
    .cam_sym   (cam_sym)
  );

  // code array written by the loader, held in flip-flops
  always_ff @(posedge clk) begin
    if (tbl_we) begin
      code_mem[tbl_idx] <= tbl_code;
      len_mem[tbl_idx]  <= tbl_len;
    end
  end

  // encoder: direct index by the byte symbol, no search
  always_ff @(posedge clk) begin
    if (srst) begin
      enc_out_valid <= 1'b0;
      enc_code      <= shc_pkg::CODE_ZERO;
      enc_len       <= shc_pkg::LEN_ZERO;
    end else begin
      enc_out_valid <= enc_valid;
      if (enc_valid) begin
        enc_code <= code_mem[enc_sym];
        enc_len  <= len_mem[enc_sym];
      end
    end
  end

  // ready only while idle: one bit per loop
  assign bit_ready = (state_q == SHC_IDLE);
  assign cif.key   = shreg_q;
  assign cif.len   = nbits_q;
  assign cif.req   = (state_q == SHC_SEARCH);

  // decode loop: shift, search, test flag
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q   <= SHC_IDLE;
      shreg_q   <= shc_pkg::CODE_ZERO;
      nbits_q   <= shc_pkg::LEN_ZERO;
      dec_valid <= 1'b0;
      dec_sym   <= '0;
      dec_err   <= 1'b0;
    end else begin
      dec_valid <= 1'b0;
      dec_err   <= 1'b0;
      unique case (state_q)
        SHC_IDLE: begin
          if (bit_valid) begin
            shreg_q <= {shreg_q[shc_pkg::CODE_W-2:0], bit_in};
            nbits_q <= nbits_q + shc_pkg::LEN_ONE;
            state_q <= SHC_SEARCH;
          end
        end
        SHC_SEARCH: begin
          state_q <= SHC_WAIT;
        end
        SHC_WAIT: begin
          if (cif.done) begin
            state_q <= SHC_IDLE;
            if (cif.hit) begin
              dec_valid <= 1'b1;
              dec_sym   <= cif.sym;
              shreg_q   <= shc_pkg::CODE_ZERO;
              nbits_q   <= shc_pkg::LEN_ZERO;
            end else if (shc_is_full(nbits_q)) begin
              dec_err <= 1'b1;
              shreg_q <= shc_pkg::CODE_ZERO;
              nbits_q <= shc_pkg::LEN_ZERO;
            end else begin
              // miss below full length keeps the bits for the next shift
              nbits_q <= nbits_q;
            end
          end
        end
      endcase
    end
  end

  // loop cycle counter, read by checks only
  always_ff @(posedge clk) begin
    if (srst || state_q == SHC_IDLE) begin
      loop_q <= '0;
    end else if (loop_q != '1) begin
      loop_q <= loop_q + CNT_ONE;
    end
  end

  property p_clear_on_hit;
    @(posedge clk) disable iff (srst)
      (state_q == SHC_WAIT && cif.done && cif.hit) |=> (nbits_q == '0 && dec_valid);
  endproperty
  a_clear_on_hit: assert property (p_clear_on_hit) else $error("hit did not clear");

  property p_keep_on_miss;
    @(posedge clk) disable iff (srst)
      (state_q == SHC_WAIT && cif.done && !cif.hit && !shc_is_full(nbits_q))
      |=> (nbits_q == $past(nbits_q) && !dec_valid);
  endproperty
  a_keep_on_miss: assert property (p_keep_on_miss) else $error("miss lost bits");

  property p_shift_one;
    @(posedge clk) disable iff (srst)
      (bit_ready && bit_valid) |=> (nbits_q == $past(nbits_q) + shc_pkg::LEN_ONE
                                     && shreg_q[0] == $past(bit_in));
  endproperty
  a_shift_one: assert property (p_shift_one) else $error("bad shift");

  property p_search_after_bit;
    @(posedge clk) disable iff (srst)
      (bit_ready && bit_valid) |=> ##1 (cam_req && cam_key == shreg_q);
  endproperty
  a_search_after_bit: assert property (p_search_after_bit) else $error("no search");

  property p_err_full;
    @(posedge clk) disable iff (srst)
      (state_q == SHC_WAIT && cif.done && !cif.hit && shc_is_full(nbits_q))
      |=> (dec_err && nbits_q == '0);
  endproperty
  a_err_full: assert property (p_err_full) else $error("no invalid code error");

  property p_len_max;
    @(posedge clk) disable iff (srst) nbits_q <= LEN_FULL;
  endproperty
  a_len_max: assert property (p_len_max) else $error("length over 48");

  property p_enc_index;
    @(posedge clk) disable iff (srst)
      enc_valid |=> (enc_out_valid && enc_code == code_mem[$past(enc_sym)]);
  endproperty
  a_enc_index: assert property (p_enc_index) else $error("encode mismatch");

  property p_one_bit_per_loop;
    @(posedge clk) disable iff (srst)
      (state_q != SHC_IDLE) |=> (nbits_q == $past(nbits_q) || nbits_q == shc_pkg::LEN_ZERO);
  endproperty
  a_one_bit_per_loop: assert property (p_one_bit_per_loop) else $error("bit mid loop");

  property p_loop_budget;
    @(posedge clk) disable iff (srst)
      (state_q == SHC_WAIT && cif.done) |-> (loop_q <= LOOP_MAX);
  endproperty
  a_loop_budget: assert property (p_loop_budget) else $error("loop over budget");

  // one search request per shifted bit, never held
  property p_req_pulse;
    @(posedge clk) disable iff (srst)
      cam_req |=> !cam_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("search request held");

  // comparand length follows the bits held
  property p_len_follows;
    @(posedge clk) disable iff (srst)
      cam_req |-> (cam_len == nbits_q);
  endproperty
  a_len_follows: assert property (p_len_follows) else $error("comparand length wrong");
endmodule : shc_converter
`default_nettype wire

// file: rtl/shc_pkg.sv
// Purpose: shared constants for the static huffman code converter
// Assumes: one clock at 250 MHz, synchronous active-high reset
// Notes:   the loop time is kept as a time and converted to cycles here
package shc_pkg;
  localparam int unsigned SYM_W       = 8;     // symbol width in bits
  localparam int unsigned CODE_W      = 48;    // longest code in bits
  localparam int unsigned LEN_W       = 6;     // width of a code length
  localparam int unsigned CLK_PS      = 4000;  // clock period in ps
  localparam int unsigned LOOP_NS     = 165;   // decode loop budget in ns
  localparam int unsigned LOOP_CYC    = (LOOP_NS * 1000) / CLK_PS; // longest, round down
  localparam int unsigned CNT_W       = 8;     // loop counter width
  localparam logic [CODE_W-1:0] CODE_ZERO = '0; // empty input register
  localparam logic [LEN_W-1:0]  LEN_ZERO  = '0; // empty length
  localparam logic [LEN_W-1:0]  LEN_ONE   = 6'h01; // one more bit
endpackage : shc_pkg

// file: rtl/shc_cam_if.sv
// Purpose: carrier between the converter core and its search port logic
// Assumes: all signals on clk
// Notes:   req starts a search, done returns hit and symbol
`timescale 1ns/1ns
`default_nettype none
interface shc_cam_if;
  logic                      req;   // search request pulse
  logic [shc_pkg::CODE_W-1:0] key;  // comparand
  logic [shc_pkg::LEN_W-1:0]  len;  // valid bits in comparand
  logic                      done;  // search finished pulse
  logic                      hit;   // match flag
  logic [shc_pkg::SYM_W-1:0] sym;   // matching symbol
  modport core (output req, output key, output len, input done, input hit, input sym);
  modport port (input req, input key, input len, output done, output hit, output sym);
endinterface : shc_cam_if
`default_nettype wire

// file: rtl/shc_cam_port.sv
// Purpose: drives the external associative memory search and returns the flag
// Assumes: memory answers with cam_ack (pulse) some cycles after cam_req
// Notes:   match flag and symbol are registered on the answer
`timescale 1ns/1ns
`default_nettype none
module shc_cam_port (
  input  wire logic                       clk,
  input  wire logic                       srst,
  shc_cam_if.port                         cif,
  output logic                            cam_req,
  output logic [shc_pkg::CODE_W-1:0]      cam_key,
  output logic [shc_pkg::LEN_W-1:0]       cam_len,
  input  wire logic                       cam_ack,
  input  wire logic                       cam_match,
  input  wire logic [shc_pkg::SYM_W-1:0]  cam_sym
);
  // present comparand and latch the answer
  always_ff @(posedge clk) begin
    if (srst) begin
      cam_req  <= 1'b0;
      cam_key  <= shc_pkg::CODE_ZERO;
      cam_len  <= shc_pkg::LEN_ZERO;
      cif.done <= 1'b0;
      cif.hit  <= 1'b0;
      cif.sym  <= '0;
    end else begin
      cam_req  <= cif.req;
      cif.done <= cam_ack;
      if (cif.req) begin
        cam_key <= cif.key;
        cam_len <= cif.len;
      end
      if (cam_ack) begin
        cif.hit <= cam_match;
        cif.sym <= cam_sym;
      end
    end
  end
endmodule : shc_cam_port
`default_nettype wire

// file: test/shc_cam_model.sv
// Purpose: behavioural associative memory on the far side of the converter
// Assumes: one answer per search, after 0 to 20 idle cycles
// Notes:   the bench fills code_a, len_a and used_a directly
`timescale 1ns/1ns
`default_nettype none
module shc_cam_model (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       cam_req,
  input  wire logic [shc_pkg::CODE_W-1:0] cam_key,
  input  wire logic [shc_pkg::LEN_W-1:0]  cam_len,
  output logic                            cam_ack,
  output logic                            cam_match,
  output logic [shc_pkg::SYM_W-1:0]       cam_sym
);
  logic [shc_pkg::CODE_W-1:0] code_a [256]; // stored codes, right-aligned
  logic [shc_pkg::LEN_W-1:0]  len_a  [256]; // stored lengths
  bit                         used_a [256]; // entry present
  logic                       hit;          // search result
  logic [shc_pkg::SYM_W-1:0]  sym;          // matching symbol
  // idle outputs at time zero
  initial begin
    cam_ack = 1'b0;
    cam_match = 1'b0;
    cam_sym = 8'h00;
  end
  // answer once per search; flag keeps toggling while unanswered, symbol holds until the answer
  always @(posedge clk) begin
    cam_ack   <= 1'b0;
    cam_match <= ~cam_match;
    cam_sym   <= ~cam_sym;
    if (cam_req === 1'b1 && srst === 1'b0) begin
      hit = 1'b0;
      sym = 8'h00;
      for (int i = 0; i < 256; i++) begin
        if (used_a[i] && len_a[i] === cam_len && code_a[i] === cam_key) begin
          hit = 1'b1;
          sym = 8'(i);
        end
      end
      repeat ($urandom_range(20, 0)) begin
        @(posedge clk);
        cam_match <= ~cam_match;
      end
      cam_ack   <= 1'b1;
      cam_match <= hit;
      cam_sym   <= sym;
    end
  end
endmodule : shc_cam_model
`default_nettype wire

// file: test/static_huffman_code_converter_tb_top.sv
// Purpose: self-checking bench for the static huffman code converter
// Assumes: 250 MHz clock, reset held for three cycles
// Notes:   reference kept in queues; memory answers at random delays
`timescale 1ns/1ns
`default_nettype none
module static_huffman_code_converter_tb_top;
  logic        clk = 1'b0, srst = 1'b1, tbl_we = 1'b0;  // clock, reset, load strobe
  logic [7:0]  tbl_idx = 8'h00, enc_sym = 8'h00;        // load index, encode symbol
  logic [47:0] tbl_code = 48'h0, rkey = 48'h0;          // load code, expected comparand
  logic [5:0]  tbl_len = 6'h00, rlen = 6'h00;           // load length, expected count
  logic        enc_valid = 1'b0, bit_valid = 1'b0, bit_in = 1'b0; // requests
  logic        enc_out_valid, bit_ready, dec_valid, dec_err, cam_req, cam_ack, cam_match;
  logic [47:0] enc_code, cam_key;                       // design outputs
  logic [5:0]  enc_len, cam_len;
  logic [7:0]  dec_sym, cam_sym;
  logic [47:0] ecode [256];                             // reference code table
  logic [5:0]  elen [256];
  int          eq [$], dq [$];                          // pending encode and decode results
  int          s, e, mismatches = 0, total_checks = 0;
  bit          took = 1'b0;                             // a bit was taken at the last edge
  always #2 clk = ~clk;
  shc_converter u_shc_converter (.clk, .srst, .tbl_we, .tbl_idx, .tbl_code, .tbl_len,
    .enc_valid, .enc_sym, .enc_out_valid, .enc_code, .enc_len, .bit_valid, .bit_in,
    .bit_ready, .dec_valid, .dec_sym, .dec_err, .cam_req, .cam_key, .cam_len, .cam_ack,
    .cam_match, .cam_sym);
  shc_cam_model u_shc_cam_model (.clk, .srst, .cam_req, .cam_key, .cam_len, .cam_ack,
    .cam_match, .cam_sym);
  // compare a code-wide value
  task automatic chk_code(input string nm, input logic [47:0] x, input logic [47:0] g);
    total_checks++;
    if (x !== g) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask : chk_code
  // compare a byte-wide value
  task automatic chk_sym(input string nm, input logic [7:0] x, input logic [7:0] g);
    total_checks++;
    if (x !== g) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask : chk_sym
  // write one table entry; cam selects whether the memory model holds it too
  task automatic load(input int i, input logic [47:0] c, input int n, input bit cam);
    tbl_we <= 1'b1;
    tbl_idx <= 8'(i);
    tbl_code <= c;
    tbl_len <= 6'(n);
    ecode[i] = c;
    elen[i] = 6'(n);
    u_shc_cam_model.code_a[i] = c;
    u_shc_cam_model.len_a[i] = 6'(n);
    u_shc_cam_model.used_a[i] = cam;
    @(posedge clk);
  endtask : load
  // offer a code msb first, one bit whenever the converter is idle
  task automatic send(input logic [47:0] c, input int n, input int x);
    int w;
    for (int i = n - 1; i >= 0; i--) begin
      bit_valid <= 1'b1;
      bit_in <= c[i];
      w = 0;
      do begin
        @(negedge clk);
        w++;
      end while (bit_ready !== 1'b1 && w < 100);
      if (bit_ready !== 1'b1) chk_sym("bit_ready", 8'h01, {7'h0, bit_ready});
      @(posedge clk);
    end
    dq.push_back(x);
  endtask : send
  // reference model: comparand, encode and decode results
  always @(posedge clk) begin
    if (took) chk_sym("bit_ready", 8'h00, {7'h0, bit_ready});
    if (cam_req === 1'b1) begin
      chk_code("cam_key", rkey, cam_key);
      chk_sym("cam_len", {2'h0, rlen}, {2'h0, cam_len});
    end
    if (enc_out_valid === 1'b1) begin
      s = eq.pop_front();
      chk_code("enc_code", ecode[s], enc_code);
      chk_sym("enc_len", {2'h0, elen[s]}, {2'h0, enc_len});
    end
    if (enc_valid && !srst) eq.push_back(enc_sym);
    if (dec_valid === 1'b1 || dec_err === 1'b1) begin
      e = (dq.size() > 0) ? dq.pop_front() : 999;
      chk_sym("dec_err", {7'h0, e < 0}, {7'h0, dec_err});
      if (e >= 0) chk_sym("dec_sym", 8'(e), dec_sym);
      rkey = '0;
      rlen = '0;
    end
    if (bit_valid && bit_ready === 1'b1 && !srst) begin
      rkey = {rkey[46:0], bit_in};
      rlen++;
    end
    took = bit_valid && bit_ready === 1'b1 && !srst;
  end
  // print the outcome and stop
  task automatic print_verdict;
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // watchdog against a hang: about 2000 stream bits of 25 cycles each, plus loading
  initial begin
    #220000;
    mismatches++;
    print_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(73876));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // outputs idle and the stream input ready right after release
    @(negedge clk);
    chk_sym("idle", 8'h01, {3'h0, cam_req, enc_out_valid, dec_valid, dec_err, bit_ready});
    @(posedge clk);
    // random table, memory side cleared; every symbol encoded back to back
    for (int i = 0; i < 256; i++) begin
      s = $urandom_range(48, 1);
      load(i, 48'({$urandom, $urandom}) & ((48'h1 << s) - 48'h1), s, 1'b0);
    end
    tbl_we <= 1'b0;
    @(posedge clk);
    for (int j = 0; j < 300; j++) begin
      enc_valid <= 1'b1;
      enc_sym <= (j < 256) ? 8'(j) : 8'($urandom);
      @(posedge clk);
    end
    enc_valid <= 1'b0;
    // let the last encode result be compared before entries are reloaded
    repeat (2) @(posedge clk);
    // prefix-free table: unary codes of 1 to 8 bits and one 48-bit code
    for (int i = 0; i < 8; i++) load(i * 29 + 3, (48'h1 << (i + 1)) - 48'h2, i + 1, 1'b1);
    load(255, 48'hffff_ffff_fffe, 48, 1'b1);
    tbl_we <= 1'b0;
    send(48'hffff_ffff_fffe, 48, 255);
    for (int j = 0; j < 40; j++) begin
      s = $urandom_range(8, 0);
      if (s == 8) send(48'hffff_ffff_fffe, 48, 255);
      else send((48'h1 << (s + 1)) - 48'h2, s + 1, s * 29 + 3);
    end
    send(48'hffff_ffff_ffff, 48, -1);
    send(48'h0, 1, 3);
    bit_valid <= 1'b0;
    repeat (100) @(posedge clk);
    chk_sym("pending", 8'h00, 8'(dq.size()));
    print_verdict();
  end
endmodule : static_huffman_code_converter_tb_top
`default_nettype wire
